// file: shared/sup_pkg.sv
// Shared constants, types and register map of the supervisor block.
package sup_pkg;

   // ****************************************************************
   // Clock and stretch timing
   // ****************************************************************
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned MS_PER_S     = 1000;
   // Stretch times in milliseconds for select codes 0 to 3.
   localparam int unsigned STRETCH_MS_0 = 50;
   localparam int unsigned STRETCH_MS_1 = 100;
   localparam int unsigned STRETCH_MS_2 = 200;
   localparam int unsigned STRETCH_MS_3 = 300;
   // Cycle counts; a least time, and all of them divide exactly.
   localparam int unsigned STRETCH_CYC_0 = STRETCH_MS_0 * (CLK_HZ / MS_PER_S);
   localparam int unsigned STRETCH_CYC_1 = STRETCH_MS_1 * (CLK_HZ / MS_PER_S);
   localparam int unsigned STRETCH_CYC_2 = STRETCH_MS_2 * (CLK_HZ / MS_PER_S);
   localparam int unsigned STRETCH_CYC_3 = STRETCH_MS_3 * (CLK_HZ / MS_PER_S);
   localparam int unsigned CNT_W         = 24;
   typedef logic [CNT_W-1:0] cnt_t;

   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [7:0] REG_CONTROL    = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h0c;
   localparam logic [2:0] DEC_CONTROL    = 3'h0;
   localparam logic [2:0] DEC_STATUS     = 3'h1;
   localparam logic [2:0] DEC_IRQ_STATUS = 3'h2;
   localparam logic [2:0] DEC_IRQ_MASK   = 3'h3;
   localparam logic [2:0] DEC_NONE       = 3'h7;
   // Control fields.
   localparam int CTL_SEL_LO  = 0;
   localparam int CTL_SEL_HI  = 1;
   localparam int CTL_PROT_LO = 2;
   localparam int CTL_PROT_HI = 3;
   localparam logic [1:0] SEL_RESET  = 2'h0;
   localparam logic [1:0] PROT_RESET = 2'h0;
   localparam logic [1:0] PROT_OFF   = 2'h0;
   // Live status fields.
   localparam int STS_RESET = 0;
   localparam int STS_V2    = 1;
   localparam int STS_V3    = 2;
   localparam int STS_WP    = 3;
   // Sticky event bits, shared by status and mask.
   localparam int IRQ_W      = 4;
   localparam int IRQ_V2     = 0;
   localparam int IRQ_V3     = 1;
   localparam int IRQ_RST    = 2;
   localparam int IRQ_WREF   = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_POR     = 2'h0,
      ST_HOLD    = 2'h1,
      ST_STRETCH = 2'h3,
      ST_RUN     = 2'h2
   } rst_state_t;

   typedef struct packed {
      logic mr;
      logic supply_low;
      logic v2;
      logic v3;
      logic wp;
   } pins_t;

   typedef struct packed {
      logic valid;
      logic nonvolatile;
   } wr_req_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;

endpackage

// file: logic/input_sync.sv
// Two-stage synchroniser for the supervisor's pin inputs.
`timescale 1ns/1ps
module input_sync (
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          arst_n,
   // Raw pins and their synchronised copies.
   input  wire sup_pkg::pins_t pins_raw,
   output      sup_pkg::pins_t pins_sync
);

   typedef struct packed {
      sup_pkg::pins_t stage1;
      sup_pkg::pins_t stage2;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // The first stage feeds only the second, so a metastable level never
   // reaches any decision logic.
   always_comb begin
      next_st        = st;
      next_st.stage1 = pins_raw;
      next_st.stage2 = st.stage1;
   end

   // All stages clear to zero, the inactive level for every pin except the two monitor inputs, where zero is the alarm level.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins_sync = st.stage2;

endmodule

// file: logic/supervisor.sv
// Reset supervisor with monitor outputs, write guard and register slave.
//
// Overview of operation
// - A high manual reset input starts a reset cycle and raises reset.
// - After manual reset drops, reset stays high for the stretch time.
// - Two select bits in the control register pick the stretch time.
// - Reset is high whenever the supply-low indication is present.
// - From power-up reset stays high until stretch after supply is good.
// - A high write-protect refuses every nonvolatile write.
// - Write-protect plus nonzero protection bits refuse every write.
// - The third fail output follows its comparator with no stretching.
// - The second fail output follows its comparator with no reset delay.
// - Stretch times span 50 to 300 ms through the select bits.
// - Monitor alarms latch into sticky status bits that stay set until a one is written to clear them.
`timescale 1ns/1ps
module supervisor #(
   parameter int unsigned STRETCH_CYC_0 = sup_pkg::STRETCH_CYC_0,
   parameter int unsigned STRETCH_CYC_1 = sup_pkg::STRETCH_CYC_1,
   parameter int unsigned STRETCH_CYC_2 = sup_pkg::STRETCH_CYC_2,
   parameter int unsigned STRETCH_CYC_3 = sup_pkg::STRETCH_CYC_3
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             arst_n,
   // Supervisor pins.
   input  wire sup_pkg::pins_t   pins,
   output      logic             reset_out,
   output      logic             second_monitor_fail_out,
   output      logic             third_monitor_fail_out,
   // Write gate for the storage and potentiometer logic.
   input  wire sup_pkg::wr_req_t wr_req,
   output      logic             wr_grant,
   output      logic             wr_refuse,
   // Register bus.
   input  wire sup_pkg::axi_req_t axi_in,
   output      sup_pkg::axi_rsp_t axi_out,
   // Interrupt.
   output      logic             irq
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      sup_pkg::rst_state_t    fsm;
      sup_pkg::cnt_t          cnt;
      logic                   reset_out;
      logic                   v2_out;
      logic                   v3_out;
      logic [1:0]             stretch_sel;
      logic [1:0]             protect;
      logic [sup_pkg::IRQ_W-1:0] irq_status;
      logic [sup_pkg::IRQ_W-1:0] irq_mask;
      logic                   irq;
      logic                   wr_grant;
      logic                   wr_refuse;
      logic                   aw_got;
      logic [7:0]             aw_addr;
      logic                   w_got;
      logic [31:0]            w_data;
      logic [3:0]             w_strb;
      sup_pkg::axi_rsp_t      rsp;
   } sup_state_t;

   sup_state_t     st;
   sup_state_t     next_st;
   sup_pkg::pins_t ps;
   sup_pkg::cnt_t  target;
   sup_pkg::cnt_t  target_m1;
   logic           src_any;
   logic           wr_block;

   // ****************************************************************
   // Input synchroniser
   // ****************************************************************
   input_sync u_input_sync (
      .clk       (clk),
      .arst_n    (arst_n),
      .pins_raw  (pins),
      .pins_sync (ps)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Maps a byte address onto a register code; unaligned is unmapped.
   function automatic logic [2:0] decode_reg(input logic [7:0] addr);
      case (addr)
         sup_pkg::REG_CONTROL:    decode_reg = sup_pkg::DEC_CONTROL;
         sup_pkg::REG_STATUS:     decode_reg = sup_pkg::DEC_STATUS;
         sup_pkg::REG_IRQ_STATUS: decode_reg = sup_pkg::DEC_IRQ_STATUS;
         sup_pkg::REG_IRQ_MASK:   decode_reg = sup_pkg::DEC_IRQ_MASK;
         default:                 decode_reg = sup_pkg::DEC_NONE;
      endcase
   endfunction

   // Picks the stretch length for a select code.
   function automatic sup_pkg::cnt_t stretch_len(input logic [1:0] sel);
      case (sel)
         2'h0:    stretch_len = sup_pkg::cnt_t'(STRETCH_CYC_0);
         2'h1:    stretch_len = sup_pkg::cnt_t'(STRETCH_CYC_1);
         2'h2:    stretch_len = sup_pkg::cnt_t'(STRETCH_CYC_2);
         default: stretch_len = sup_pkg::cnt_t'(STRETCH_CYC_3);
      endcase
   endfunction

   // Stretch target follows the live select bits; a change mid-stretch
   // takes effect at once rather than waiting for the next cycle.
   always_comb begin
      target    = stretch_len(st.stretch_sel);
      target_m1 = target - sup_pkg::cnt_t'(1);
   end

   // Any reset source, after synchronisation.
   assign src_any  = ps.mr | ps.supply_low;
   // Volatile writes are blocked only with protection bits set.
   assign wr_block = ps.wp & (st.protect != sup_pkg::PROT_OFF);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [2:0]                wdec;
      logic [2:0]                rdec;
      logic [sup_pkg::IRQ_W-1:0] clr;
      logic [sup_pkg::IRQ_W-1:0] set;
      logic [31:0]               rword;
      wdec    = sup_pkg::DEC_NONE;
      rdec    = sup_pkg::DEC_NONE;
      clr     = '0;
      set     = '0;
      rword   = '0;
      next_st = st;

      // Reset sequencer: hold while a source is present, then stretch.
      case (st.fsm)
         sup_pkg::ST_POR, sup_pkg::ST_HOLD: begin
            next_st.cnt = '0;
            if (src_any) begin
               next_st.fsm = sup_pkg::ST_HOLD;
            end else begin
               next_st.fsm = sup_pkg::ST_STRETCH;
            end
         end
         sup_pkg::ST_STRETCH: begin
            if (src_any) begin
               next_st.fsm = sup_pkg::ST_HOLD;
               next_st.cnt = '0;
            end else if (st.cnt >= target_m1) begin
               next_st.fsm = sup_pkg::ST_RUN;
               next_st.cnt = '0;
            end else begin
               next_st.cnt = st.cnt + sup_pkg::cnt_t'(1);
            end
         end
         sup_pkg::ST_RUN: begin
            if (src_any) begin
               next_st.fsm = sup_pkg::ST_HOLD;
            end
         end
         default: begin
            next_st.fsm = sup_pkg::ST_POR;
            next_st.cnt = '0;
         end
      endcase
      next_st.reset_out = (next_st.fsm != sup_pkg::ST_RUN);

      // Monitor outputs: one register stage, no filtering.
      next_st.v2_out = ps.v2;
      next_st.v3_out = ps.v3;

      // Write gate answers each request with a one-cycle pulse.
      next_st.wr_grant  = 1'b0;
      next_st.wr_refuse = 1'b0;
      if (wr_req.valid) begin
         if (wr_block || (ps.wp && wr_req.nonvolatile)) begin
            next_st.wr_refuse = 1'b1;
         end else begin
            next_st.wr_grant = 1'b1;
         end
      end

      // Events: alarm is a comparator below its trip level.
      set[sup_pkg::IRQ_V2]   = ~ps.v2;
      set[sup_pkg::IRQ_V3]   = ~ps.v3;
      set[sup_pkg::IRQ_RST]  = src_any;
      set[sup_pkg::IRQ_WREF] = next_st.wr_refuse;

      // Write channel: address and data are taken in either order.
      if (axi_in.awvalid && st.rsp.awready) begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = axi_in.awaddr;
      end
      if (axi_in.wvalid && st.rsp.wready) begin
         next_st.w_got  = 1'b1;
         next_st.w_data = axi_in.wdata;
         next_st.w_strb = axi_in.wstrb;
      end
      if (st.rsp.bvalid && axi_in.bready) begin
         next_st.rsp.bvalid = 1'b0;
      end
      if (next_st.aw_got && next_st.w_got && !next_st.rsp.bvalid) begin
         wdec               = decode_reg(next_st.aw_addr);
         next_st.aw_got     = 1'b0;
         next_st.w_got      = 1'b0;
         next_st.rsp.bvalid = 1'b1;
         next_st.rsp.bresp  = sup_pkg::RESP_OKAY;
         // All fields sit in byte lane 0; other lanes carry nothing.
         if (next_st.w_strb[0]) begin
            case (wdec)
               sup_pkg::DEC_CONTROL: begin
                  next_st.stretch_sel = next_st.w_data[
                     sup_pkg::CTL_SEL_HI:sup_pkg::CTL_SEL_LO];
                  next_st.protect = next_st.w_data[
                     sup_pkg::CTL_PROT_HI:sup_pkg::CTL_PROT_LO];
               end
               sup_pkg::DEC_IRQ_STATUS: begin
                  clr = next_st.w_data[sup_pkg::IRQ_W-1:0];
               end
               sup_pkg::DEC_IRQ_MASK: begin
                  next_st.irq_mask = next_st.w_data[sup_pkg::IRQ_W-1:0];
               end
               default: begin
               end
            endcase
         end
         if (wdec == sup_pkg::DEC_NONE) begin
            next_st.rsp.bresp = sup_pkg::RESP_SLVERR;
         end
      end
      next_st.rsp.awready = !next_st.aw_got && !next_st.rsp.bvalid;
      next_st.rsp.wready  = !next_st.w_got && !next_st.rsp.bvalid;

      // Sticky bits: a new event in the clearing cycle wins.
      next_st.irq_status = (st.irq_status & ~clr) | set;
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);

      // Read channel: one read outstanding, answered the next cycle.
      if (st.rsp.rvalid && axi_in.rready) begin
         next_st.rsp.rvalid = 1'b0;
      end
      if (axi_in.arvalid && st.rsp.arready) begin
         rdec = decode_reg(axi_in.araddr);
         case (rdec)
            sup_pkg::DEC_CONTROL: begin
               rword[sup_pkg::CTL_SEL_HI:sup_pkg::CTL_SEL_LO] =
                  st.stretch_sel;
               rword[sup_pkg::CTL_PROT_HI:sup_pkg::CTL_PROT_LO] = st.protect;
            end
            sup_pkg::DEC_STATUS: begin
               rword[sup_pkg::STS_RESET] = st.reset_out;
               rword[sup_pkg::STS_V2]    = ps.v2;
               rword[sup_pkg::STS_V3]    = ps.v3;
               rword[sup_pkg::STS_WP]    = ps.wp;
            end
            sup_pkg::DEC_IRQ_STATUS: begin
               rword[sup_pkg::IRQ_W-1:0] = st.irq_status;
            end
            sup_pkg::DEC_IRQ_MASK: begin
               rword[sup_pkg::IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
               rword = '0;
            end
         endcase
         next_st.rsp.rvalid = 1'b1;
         next_st.rsp.rdata  = rword;
         next_st.rsp.rresp  = (rdec == sup_pkg::DEC_NONE) ?
                              sup_pkg::RESP_SLVERR : sup_pkg::RESP_OKAY;
      end
      next_st.rsp.arready = !next_st.rsp.rvalid;
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Reset comes up asserted: the system is held from the first edge.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st             <= '0;
         st.fsm         <= sup_pkg::ST_POR;
         st.reset_out   <= 1'b1;
         st.stretch_sel <= sup_pkg::SEL_RESET;
         st.protect     <= sup_pkg::PROT_RESET;
         st.irq_status  <= sup_pkg::IRQ_RESET;
         st.irq_mask    <= sup_pkg::IRQ_RESET;
         st.rsp.awready <= 1'b1;
         st.rsp.wready  <= 1'b1;
         st.rsp.arready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register.
   assign reset_out               = st.reset_out;
   assign second_monitor_fail_out = st.v2_out;
   assign third_monitor_fail_out  = st.v3_out;
   assign wr_grant                = st.wr_grant;
   assign wr_refuse               = st.wr_refuse;
   assign axi_out                 = st.rsp;
   assign irq                     = st.irq;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_MR_RAISES_RESET: assert property (ps.mr |=> reset_out)
      else $error("Manual reset did not raise reset.");
   AST_STRETCH_LENGTH: assert property (
      $fell(reset_out) |-> $past(st.cnt) == $past(target_m1))
      else $error("Reset released before the stretch time.");
   AST_SEL_TARGET: assert property (
      st.stretch_sel == 2'h3 |-> target == sup_pkg::cnt_t'(STRETCH_CYC_3))
      else $error("Stretch select gave the wrong length.");
   AST_SUPPLY_LOW: assert property (ps.supply_low |=> reset_out)
      else $error("Supply low did not hold reset.");
   AST_POR_HELD: assert property (
      st.fsm == sup_pkg::ST_POR |-> reset_out ##1 reset_out)
      else $error("Reset dropped straight after power-up.");
   AST_NV_REFUSED: assert property (
      wr_req.valid && wr_req.nonvolatile && ps.wp |=> wr_refuse && !wr_grant)
      else $error("Nonvolatile write passed write-protect.");
   AST_ALL_REFUSED: assert property (
      wr_req.valid && wr_block |=> wr_refuse && !wr_grant)
      else $error("Write passed write-protect with protection set.");
   AST_VOL_ALLOWED: assert property (
      wr_req.valid && !wr_req.nonvolatile && !wr_block |=> wr_grant)
      else $error("Volatile write wrongly refused.");
   AST_V3_FOLLOW: assert property (
      third_monitor_fail_out == $past(ps.v3))
      else $error("Third fail output does not follow its comparator.");
   AST_V2_FOLLOW: assert property (
      second_monitor_fail_out == $past(ps.v2))
      else $error("Second fail output does not follow its comparator.");
   AST_STRETCH_BOUND: assert property (
      st.fsm == sup_pkg::ST_STRETCH |-> st.cnt <= target_m1)
      else $error("Stretch counter ran past its target.");
   AST_ALARM_STICKY: assert property (
      !ps.v2 |=> st.irq_status[sup_pkg::IRQ_V2] [*2])
      else $error("Second monitor alarm not latched.");
   AST_TIMER_RESTART: assert property (
      src_any |=> st.cnt == '0 && st.fsm == sup_pkg::ST_HOLD)
      else $error("Reset source did not restart the stretch timer.");

   COV_MR_CYCLE: cover property (
      $rose(ps.mr) ##[1:300] $fell(reset_out));
   COV_SUPPLY_DIP: cover property (
      st.fsm == sup_pkg::ST_RUN ##1 ps.supply_low);
   COV_WRITE_REFUSED: cover property (wr_refuse && irq);
   COV_RESTART: cover property (
      st.fsm == sup_pkg::ST_STRETCH ##1 st.fsm == sup_pkg::ST_HOLD);

endmodule

// file: verif/proc_model.sv
// Processor model that the supervisor holds in reset.
`timescale 1ns/1ps
module proc_model (
   // Clock and the reset that holds the processor.
   input  wire logic       clk,
   input  wire logic       reset_out,
   // Cycles run since reset was released.
   output      logic [7:0] run_cycles
);
   // The count saturates so that a long run never wraps back to zero.
   always_ff @(posedge clk or posedge reset_out) begin
      if (reset_out) begin
         run_cycles <= 8'h00;
      end else if (run_cycles != 8'hff) begin
         run_cycles <= run_cycles + 8'h01;
      end
   end
endmodule

// file: verif/supervisor_test.sv
// Self-checking bench for the supervisor block.
`timescale 1ns/1ps
module supervisor_test;
   // Short stretch counts keep the run brief.
   localparam int C [4] = '{4, 6, 8, 10};
   logic              clk;
   logic              arst_n;
   sup_pkg::pins_t    pins;
   sup_pkg::wr_req_t  wr_req;
   sup_pkg::axi_req_t axi_in;
   sup_pkg::axi_rsp_t axi_out;
   logic              reset_out, f2, f3, wr_grant, wr_refuse, irq;
   logic [7:0]        run_cycles;
   logic [31:0]       d;
   logic [1:0]        r;
   int                fails, comparisons, n;
   int                cyc = 0;

   supervisor #(.STRETCH_CYC_0(C[0]), .STRETCH_CYC_1(C[1]),
      .STRETCH_CYC_2(C[2]), .STRETCH_CYC_3(C[3])) u_supervisor (
      .clk(clk), .arst_n(arst_n), .pins(pins), .reset_out(reset_out),
      .second_monitor_fail_out(f2), .third_monitor_fail_out(f3),
      .wr_req(wr_req), .wr_grant(wr_grant), .wr_refuse(wr_refuse),
      .axi_in(axi_in), .axi_out(axi_out), .irq(irq));
   proc_model u_proc_model (.clk(clk), .reset_out(reset_out),
      .run_cycles(run_cycles));

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // A hang ends the run as a failure.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         wrap_up();
      end
   end

   // Compares a value; four-state equality keeps unknowns from passing.
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Write: address and data offered together, each dropped when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      axi_in.awvalid <= 1'b1;
      axi_in.awaddr <= a;
      axi_in.wvalid <= 1'b1;
      axi_in.wdata <= v;
      axi_in.wstrb <= 4'hf;
      axi_in.bready <= 1'b1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && axi_out.awready === 1'b1) begin
            aw = 1'b0;
            axi_in.awvalid <= 1'b0;
         end
         if (w && axi_out.wready === 1'b1) begin
            w = 1'b0;
            axi_in.wvalid <= 1'b0;
         end
      end
      while (axi_out.bvalid !== 1'b1) @(posedge clk);
      r = axi_out.bresp;
      axi_in.bready <= 1'b0;
   endtask

   // Read: data and response are taken at the rvalid edge.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      axi_in.arvalid <= 1'b1;
      axi_in.araddr <= a;
      axi_in.rready <= 1'b1;
      do @(posedge clk); while (axi_out.arready !== 1'b1);
      axi_in.arvalid <= 1'b0;
      while (axi_out.rvalid !== 1'b1) @(posedge clk);
      d = axi_out.rdata;
      r = axi_out.rresp;
      axi_in.rready <= 1'b0;
   endtask

   // Counts the edges after which reset is still high.
   task automatic count_high();
      n = 0;
      @(posedge clk);
      #1;
      while (reset_out === 1'b1 && n < 40) begin
         n++;
         @(posedge clk);
         #1;
      end
   endtask

   // Raises a reset source; a gap re-raises it during the stretch.
   task automatic pulse(input int b, input int sel, input bit gap);
      wr(sup_pkg::REG_CONTROL, sel);
      @(posedge clk);
      pins[b] <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("reset on source", 1, reset_out);
      @(posedge clk);
      pins[b] <= 1'b0;
      if (gap) begin
         repeat (4) @(posedge clk);
         pins[b] <= 1'b1;
         repeat (3) @(posedge clk);
         pins[b] <= 1'b0;
      end
      count_high();
      chk("stretch", C[sel] + 2, n);
   endtask

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      pins = 5'h06;
      wr_req = '0;
      axi_in = '0;
      fails = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      #1 chk("reset at power-up", 1, reset_out);
      count_high();
      chk("power-up stretch", C[0], n);
      repeat (2) @(posedge clk);
      #1 chk("processor running", 8'h02, run_cycles);
      rd(sup_pkg::REG_CONTROL);
      chk("control reset", 0, d);
      rd(sup_pkg::REG_IRQ_MASK);
      chk("mask reset", 0, d);
      rd(sup_pkg::REG_STATUS);
      chk("status", 32'h6, d);
      rd(8'h10);
      chk("unmapped read", sup_pkg::RESP_SLVERR, r);
      chk("unmapped data", 0, d);
      wr(8'h10, 32'h1);
      chk("unmapped write", sup_pkg::RESP_SLVERR, r);
      for (int s = 0; s < 4; s++) begin
         pulse(s[0] ? 3 : 4, s, 1'b0);
      end
      pulse(4, 0, 1'b1);
      wr(sup_pkg::REG_IRQ_STATUS, 32'h3);
      chk("write okay", sup_pkg::RESP_OKAY, r);
      rd(sup_pkg::REG_IRQ_STATUS);
      chk("read okay", sup_pkg::RESP_OKAY, r);
      chk("alarms clear first", 2'h0, d[1:0]);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         pins.v2 <= i[0];
         pins.v3 <= i[1];
         repeat (3) @(posedge clk);
         #1 chk("second fail", i[0], f2);
         chk("third fail", i[1], f3);
      end
      rd(sup_pkg::REG_IRQ_STATUS);
      chk("alarms latched", 2'h3, d[1:0]);
      wr(sup_pkg::REG_IRQ_STATUS, 32'h3);
      rd(sup_pkg::REG_IRQ_STATUS);
      chk("alarms cleared", 2'h0, d[1:0]);
      for (int p = 0; p < 4; p++) begin
         wr(sup_pkg::REG_CONTROL, p << 2);
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            pins.wp <= k[1];
            repeat (3) @(posedge clk);
            wr_req <= {1'b1, k[0]};
            @(posedge clk);
            wr_req.valid <= 1'b0;
            #1 chk("refuse", k[1] && (k[0] || p), wr_refuse);
            chk("grant", !(k[1] && (k[0] || p)), wr_grant);
         end
      end
      wr(sup_pkg::REG_IRQ_MASK, 32'h8);
      #1 chk("irq raised", 1, irq);
      @(posedge clk);
      pins.wp <= 1'b0;
      wr(sup_pkg::REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk("irq masked", 0, irq);
      wr(sup_pkg::REG_IRQ_STATUS, 32'h8);
      wr(sup_pkg::REG_IRQ_MASK, 32'h8);
      repeat (2) @(posedge clk);
      #1 chk("irq cleared", 0, irq);
      wrap_up();
   end
endmodule
